// file: hw/twmt_bit_engine.sv
/*
  Bit engine: produces start, stop, data bit and acknowledge slots on the
  open-drain clock and data lines, checks arbitration and watches the bus
  for start and stop conditions from any master.
  Assumes pull-ups on both lines and a caller that issues a command only
  while the engine is idle (no command outstanding).
*/
`timescale 1ns/1ps
module twmt_bit_engine
  import twmt_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst_b,
  input  wire logic      scl_i,
  output logic           scl_o,
  output logic           scl_oe,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe,
  input  wire logic      cmd_valid,
  input  wire twmt_cmd_e cmd_code,
  input  wire logic      cmd_bit,
  output logic           done,
  output logic           rx_bit,
  output logic           arb_lost,
  output logic           bus_busy
);

  typedef enum logic [1:0] {PH_SETUP, PH_RISE, PH_HIGH, PH_FALL} twmt_phase_e;

  logic        scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic        sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic [7:0]  tick_cnt_reg;
  logic        tick;
  logic        active_reg;
  twmt_cmd_e   cmd_reg;
  logic        bit_reg;
  twmt_phase_e phase_reg;

  // open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // two-stage synchronisers, prev stage for edge detection
  always_ff @(posedge clk_sys)
  begin
    scl_meta_reg <= scl_i;
    scl_sync_reg <= scl_meta_reg;
    scl_prev_reg <= scl_sync_reg;
    sda_meta_reg <= sda_i;
    sda_sync_reg <= sda_meta_reg;
    sda_prev_reg <= sda_sync_reg;
  end

  // quarter bit-period enable
  assign tick = (tick_cnt_reg == QTR_LAST);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || tick)
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
  end

  // bus busy between any start and the next stop
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      bus_busy <= 1'b0;
    else if (scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg)
      bus_busy <= 1'b1;
    else if (scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg)
      bus_busy <= 1'b0;
  end

  // slot sequencer; line drive persists while idle, so clock stays low after start, bit and ack slots, except a bit slot that loses arbitration
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      active_reg <= 1'b0;
      cmd_reg    <= CMD_START;
      bit_reg    <= 1'b1;
      phase_reg  <= PH_SETUP;
      scl_oe     <= 1'b0;
      sda_oe     <= 1'b0;
      done       <= 1'b0;
      arb_lost   <= 1'b0;
      rx_bit     <= 1'b1;
    end
    else
    begin
      done     <= 1'b0;
      arb_lost <= 1'b0;
      if (!active_reg && cmd_valid)
      begin
        active_reg <= 1'b1;
        cmd_reg    <= cmd_code;
        bit_reg    <= cmd_bit;
        phase_reg  <= PH_SETUP;
      end
      else if (active_reg && tick)
      begin
        case (phase_reg)
          PH_SETUP:
          begin
            sda_oe    <= (cmd_reg == CMD_STOP) || (cmd_reg == CMD_BIT && !bit_reg);
            phase_reg <= PH_RISE;
          end
          PH_RISE:
          begin
            scl_oe    <= 1'b0;
            phase_reg <= PH_HIGH;
          end
          PH_HIGH:
            // slave may stretch: wait for the clock to be seen high
            if (scl_sync_reg)
            begin
              rx_bit    <= sda_sync_reg;
              phase_reg <= PH_FALL;
              if (cmd_reg == CMD_START)
                sda_oe <= 1'b1;
              else if (cmd_reg == CMD_STOP)
                sda_oe <= 1'b0;
              else if (cmd_reg == CMD_BIT && bit_reg && !sda_sync_reg)
              begin
                // another master drives low: let go of both lines at once
                sda_oe     <= 1'b0;
                active_reg <= 1'b0;
                done       <= 1'b1;
                arb_lost   <= 1'b1;
              end
            end
          PH_FALL:
          begin
            scl_oe     <= (cmd_reg != CMD_STOP);
            active_reg <= 1'b0;
            done       <= 1'b1;
          end
          default: phase_reg <= PH_SETUP;
        endcase
      end
    end
  end

endmodule

// file: hw/twmt_pkg.sv
/*
  Shared constants for the two-wire master transmitter: register map,
  control and interrupt bit positions, bus status codes, bit engine
  command codes and bus timing.
  Assumes a 10 MHz system clock and byte addressing on the register bus.
*/
package twmt_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_DATA     = 8'h08;
  localparam logic [7:0] A_IRQ_STAT = 8'h0C;
  localparam logic [7:0] A_IRQ_MASK = 8'h10;

  // bus_control_reg bit positions
  localparam int CTRL_FLAG_B  = 0;
  localparam int CTRL_START_B = 1;
  localparam int CTRL_STOP_B  = 2;
  localparam int CTRL_ACKEN_B = 3;
  localparam int CTRL_MRX_B   = 4;

  // interrupt status and mask bits
  localparam int IRQ_W      = 2;
  localparam int IRQ_DONE_B = 0;
  localparam int IRQ_ARB_B  = 1;

  // bus_status_code_reg values
  localparam logic [7:0] ST_START    = 8'h08;
  localparam logic [7:0] ST_RESTART  = 8'h10;
  localparam logic [7:0] ST_AW_ACK   = 8'h18;
  localparam logic [7:0] ST_AW_NACK  = 8'h20;
  localparam logic [7:0] ST_DB_ACK   = 8'h28;
  localparam logic [7:0] ST_DB_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_MR_ACK   = 8'h40;
  localparam logic [7:0] ST_MR_NACK  = 8'h48;
  localparam logic [7:0] ST_IDLE     = 8'hF8;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing: bus clock period and its quarter in system cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  localparam int QTR_CYC_RAW   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_CYC       = (QTR_CYC_RAW < 1) ? 1 : QTR_CYC_RAW;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;

  // bit engine commands
  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_BIT, CMD_ACK} twmt_cmd_e;

endpackage

// file: hw/twmt_top.sv
/*
  Two-wire master transmitter with an AXI4-Lite register slave: posts a
  status code after each bus event, sets the operation done flag except after a stop, and
  waits for software to pick the next start, address, data or stop.
  Assumes pull-ups on both bus lines and a single-clock system; the bus
  lines are asynchronous and synchronised inside the bit engine.
*/
// How it works
// - each master-transmit bus event posts a status code for software to read
// - after start, status 08; loaded address-with-write frame is sent, ack sampled
// - after repeated start, status 10; address-with-write frame sent likewise
// - in status 10, an address-with-read frame is sent, then receiver mode
// - address-with-write sent: status 18 on ack, 20 on no ack
// - data byte sent: status 28 on ack, 30 on no ack
// - in 18 to 30, start 0 stop 0 done 1 sends the data byte
// - in 18 to 30, start 1 stop 0 sends a repeated start
// - in 18 to 30, stop 1 sends stop and self-clears stop flag
// - in 18 to 30, start 1 stop 1 sends stop then start
// - lost arbitration in address or data posts status 38
// - in 38, start 0 releases bus, not-addressed slave state
// - in 38, start 1 waits for free bus then sends start
`timescale 1ns/1ps
module twmt_top
  import twmt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);

  typedef enum logic [2:0] {SQ_IDLE, SQ_FREE, SQ_START, SQ_BITS, SQ_ACK, SQ_STOP,
                            SQ_WAIT} twmt_seq_e;

  logic             aw_held_reg, w_held_reg;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             wr_go, wr_ctrl, wr_data, wr_mask, wr_hit, ar_fire;
  logic             rd_hit;
  logic [31:0]      rd_word;
  logic             go, w_start, w_stop, data_code;
  logic             done_flag_reg, start_req_reg, stop_req_reg, ack_en_reg;
  logic [7:0]       status_reg, bus_byte_reg, shift_reg;
  logic [2:0]       bit_cnt_reg;
  twmt_seq_e        seq_reg;
  logic             own_bus_reg, addr_phase_reg, rw_reg, rx_mode_reg;
  logic             restart_after_stop_reg, issued_reg, flag_set;
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
  logic             eng_cmd_valid, eng_cmd_bit, eng_done, eng_rx, eng_arb;
  logic             eng_bus_busy;
  twmt_cmd_e        eng_cmd_code;

  // write channel: address and data taken in either order, one at a time
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_go   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_hit  = (aw_addr_reg == A_CTRL) || (aw_addr_reg == A_STATUS) ||
                   (aw_addr_reg == A_DATA) || (aw_addr_reg == A_IRQ_STAT) ||
                   (aw_addr_reg == A_IRQ_MASK);
  assign wr_ctrl = wr_go && w_strb_reg[0] && (aw_addr_reg == A_CTRL);
  assign wr_data = wr_go && w_strb_reg[0] && (aw_addr_reg == A_DATA);
  assign wr_mask = wr_go && w_strb_reg[0] && (aw_addr_reg == A_IRQ_MASK);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_reg <= 1'b0;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: data one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      A_CTRL:     rd_word = {27'h0, rx_mode_reg, ack_en_reg, stop_req_reg,
                             start_req_reg, done_flag_reg};
      A_STATUS:   rd_word = {24'h0, status_reg};
      A_DATA:     rd_word = {24'h0, bus_byte_reg};
      A_IRQ_STAT: rd_word = {30'h0, irq_stat_reg};
      A_IRQ_MASK: rd_word = {30'h0, irq_mask_reg};
      default:    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // software go: control write with a one in the done flag position
  assign w_start   = w_data_reg[CTRL_START_B];
  assign w_stop    = w_data_reg[CTRL_STOP_B];
  assign go        = wr_ctrl && w_data_reg[CTRL_FLAG_B];
  assign data_code = (status_reg == ST_AW_ACK) || (status_reg == ST_AW_NACK) ||
                     (status_reg == ST_DB_ACK) || (status_reg == ST_DB_NACK) ||
                     (status_reg == ST_MR_ACK) || (status_reg == ST_MR_NACK);
  assign flag_set  = eng_done && ((seq_reg == SQ_START) || (seq_reg == SQ_ACK) ||
                                  (seq_reg == SQ_BITS && eng_arb));

  // control bits; hardware set of the flag wins over a software clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      done_flag_reg <= 1'b0;
      start_req_reg <= 1'b0;
      stop_req_reg  <= 1'b0;
      ack_en_reg    <= 1'b0;
      bus_byte_reg  <= 8'h00;
    end
    else
    begin
      if (flag_set)
        done_flag_reg <= 1'b1;
      else if (go)
        done_flag_reg <= 1'b0;
      if (seq_reg == SQ_STOP && eng_done)
        stop_req_reg <= 1'b0;
      if (wr_ctrl)
      begin
        start_req_reg <= w_start;
        stop_req_reg  <= w_stop;
        ack_en_reg    <= w_data_reg[CTRL_ACKEN_B];
      end
      if (wr_data)
        bus_byte_reg <= w_data_reg[7:0];
    end
  end

  // engine command follows the sequencer state, issued once per slot
  assign eng_cmd_valid = !issued_reg && ((seq_reg == SQ_START) || (seq_reg == SQ_BITS) ||
                                         (seq_reg == SQ_ACK) || (seq_reg == SQ_STOP));
  assign eng_cmd_bit   = (seq_reg == SQ_BITS) ? shift_reg[7] : 1'b1;
  always_comb
  begin
    case (seq_reg)
      SQ_START: eng_cmd_code = CMD_START;
      SQ_STOP:  eng_cmd_code = CMD_STOP;
      SQ_ACK:   eng_cmd_code = CMD_ACK;
      default:  eng_cmd_code = CMD_BIT;
    endcase
  end

  // byte sequencer; acknowledge enable is deliberately never consulted
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      seq_reg                <= SQ_IDLE;
      status_reg             <= ST_IDLE;
      shift_reg              <= 8'h00;
      bit_cnt_reg            <= 3'h0;
      own_bus_reg            <= 1'b0;
      addr_phase_reg         <= 1'b0;
      rw_reg                 <= 1'b0;
      rx_mode_reg            <= 1'b0;
      restart_after_stop_reg <= 1'b0;
      issued_reg             <= 1'b0;
    end
    else
    begin
      if (eng_done)
        issued_reg <= 1'b0;
      else if (eng_cmd_valid)
        issued_reg <= 1'b1;
      case (seq_reg)
        SQ_IDLE:
          if (go && w_start)
            seq_reg <= SQ_FREE;
        SQ_FREE:
          if (!eng_bus_busy)
            seq_reg <= SQ_START;
        SQ_START:
          if (eng_done)
          begin
            status_reg     <= own_bus_reg ? ST_RESTART : ST_START;
            own_bus_reg    <= 1'b1;
            addr_phase_reg <= 1'b1;
            rx_mode_reg    <= 1'b0;
            seq_reg        <= SQ_WAIT;
          end
        SQ_BITS:
          if (eng_done && eng_arb)
          begin
            status_reg  <= ST_ARB_LOST;
            own_bus_reg <= 1'b0;
            seq_reg     <= SQ_WAIT;
          end
          else if (eng_done)
          begin
            shift_reg   <= {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == BIT_LAST)
              seq_reg <= SQ_ACK;
          end
        SQ_ACK:
          if (eng_done)
          begin
            addr_phase_reg <= 1'b0;
            seq_reg        <= SQ_WAIT;
            if (addr_phase_reg && rw_reg)
            begin
              rx_mode_reg <= 1'b1;
              status_reg  <= eng_rx ? ST_MR_NACK : ST_MR_ACK;
            end
            else if (addr_phase_reg)
              status_reg <= eng_rx ? ST_AW_NACK : ST_AW_ACK;
            else
              status_reg <= eng_rx ? ST_DB_NACK : ST_DB_ACK;
          end
        SQ_STOP:
          if (eng_done)
          begin
            own_bus_reg <= 1'b0;
            rx_mode_reg <= 1'b0;
            if (restart_after_stop_reg)
              seq_reg <= SQ_START;
            else
            begin
              seq_reg    <= SQ_IDLE;
              status_reg <= ST_IDLE;
            end
          end
        SQ_WAIT:
          // bus clock stays low here, except after lost arbitration, until software writes the flag
          if (go)
          begin
            if ((status_reg == ST_START || status_reg == ST_RESTART) && !w_stop)
            begin
              shift_reg   <= bus_byte_reg;
              rw_reg      <= bus_byte_reg[0];
              bit_cnt_reg <= 3'h0;
              seq_reg     <= SQ_BITS;
            end
            else if (data_code && !w_stop && !w_start)
            begin
              shift_reg   <= bus_byte_reg;
              bit_cnt_reg <= 3'h0;
              seq_reg     <= SQ_BITS;
            end
            else if (data_code && w_start && !w_stop)
              seq_reg <= SQ_START;
            else if (data_code && w_stop)
            begin
              restart_after_stop_reg <= w_start;
              seq_reg                <= SQ_STOP;
            end
            else if (status_reg == ST_ARB_LOST && w_start)
              seq_reg <= SQ_FREE;
            else if (status_reg == ST_ARB_LOST)
            begin
              seq_reg    <= SQ_IDLE;
              status_reg <= ST_IDLE;
            end
          end
        default: seq_reg <= SQ_IDLE;
      endcase
    end
  end

  // sticky events, cleared by a read of the interrupt status word; set wins
  assign irq_ev[IRQ_DONE_B] = flag_set;
  assign irq_ev[IRQ_ARB_B]  = flag_set && (seq_reg == SQ_BITS);
  assign irq = |(irq_stat_reg & irq_mask_reg);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end
    else
    begin
      irq_stat_reg <= ((ar_fire && s_axi_araddr == A_IRQ_STAT) ? '0 : irq_stat_reg) | irq_ev;
      if (wr_mask)
        irq_mask_reg <= w_data_reg[IRQ_W-1:0];
    end
  end

  twmt_bit_engine u_eng (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .scl_i     (scl_i),
    .scl_o     (scl_o),
    .scl_oe    (scl_oe),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe    (sda_oe),
    .cmd_valid (eng_cmd_valid),
    .cmd_code  (eng_cmd_code),
    .cmd_bit   (eng_cmd_bit),
    .done      (eng_done),
    .rx_bit    (eng_rx),
    .arb_lost  (eng_arb),
    .bus_busy  (eng_bus_busy)
  );

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_addr_status;
    (seq_reg == SQ_ACK && eng_done && addr_phase_reg && !rw_reg) |=>
      (status_reg == ($past(eng_rx) ? ST_AW_NACK : ST_AW_ACK)) && done_flag_reg;
  endproperty
  a_addr_status: assert property (p_addr_status) else $error("bad address status");
  property p_data_status;
    (seq_reg == SQ_ACK && eng_done && !addr_phase_reg) |=>
      (status_reg == ($past(eng_rx) ? ST_DB_NACK : ST_DB_ACK)) && done_flag_reg;
  endproperty
  a_data_status: assert property (p_data_status) else $error("bad data status");
  property p_arb_status;
    (seq_reg == SQ_BITS && eng_done && eng_arb) |=> status_reg == ST_ARB_LOST && !scl_oe;
  endproperty
  a_arb_status: assert property (p_arb_status) else $error("arbitration not posted");
  property p_hold_low;
    (done_flag_reg && status_reg != ST_ARB_LOST) |-> scl_oe && !eng_cmd_valid;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock not held low");
  property p_addr_go;
    (go && seq_reg == SQ_WAIT && status_reg == ST_RESTART && !w_stop) |=>
      seq_reg == SQ_BITS && eng_cmd_valid ##1 !done_flag_reg;
  endproperty
  a_addr_go: assert property (p_addr_go) else $error("address not sent");
  property p_restart;
    (go && seq_reg == SQ_WAIT && data_code && w_start && !w_stop) |=> seq_reg == SQ_START;
  endproperty
  a_restart: assert property (p_restart) else $error("repeated start not sent");
  property p_stop_clr;
    (seq_reg == SQ_STOP && eng_done) |=> !stop_req_reg &&
      (seq_reg == ($past(restart_after_stop_reg) ? SQ_START : SQ_IDLE));
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop flag not cleared");
  property p_wait_free;
    (seq_reg == SQ_FREE && eng_bus_busy) |=> seq_reg == SQ_FREE && !eng_cmd_valid && !sda_oe;
  endproperty
  a_wait_free: assert property (p_wait_free) else $error("start on busy bus");
  property p_release;
    (go && seq_reg == SQ_WAIT && status_reg == ST_ARB_LOST && !w_start) |=>
      seq_reg == SQ_IDLE && status_reg == ST_IDLE && !done_flag_reg;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  c_arb: cover property (seq_reg == SQ_BITS && eng_done && eng_arb);
  c_stop_start: cover property (seq_reg == SQ_STOP && eng_done && restart_after_stop_reg);
  c_read_addr: cover property (seq_reg == SQ_ACK && eng_done && addr_phase_reg && rw_reg);

endmodule

// file: verification/twmt_slave_model.sv
/*
  Two-wire slave model: acks each byte, refuses it when nack is high,
  and pulls the data line low during data bits when lose is high.
  Assumes resolved bus levels with pull-ups on both lines.
*/
`timescale 1ns/1ps
module twmt_slave_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack,
  input  wire logic lose,
  output logic      sda_pull
);
  int   bit_cnt = 0;
  logic ack_pull = 1'h0;
  logic arm = 1'h0;

  // start seen: a new frame begins
  always @(negedge sda)
    if (scl)
      bit_cnt = 0;
  always @(posedge scl)
    bit_cnt = bit_cnt + 1;
  // ack slot after the eighth bit, line freed after the ninth
  always @(negedge scl)
  begin
    arm = lose;
    if (bit_cnt == 8)
      ack_pull = !nack;
    if (bit_cnt == 9)
      ack_pull = 1'h0;
    if (bit_cnt == 9)
      bit_cnt = 0;
  end
  // dropping lose frees the line while clock is high: a stop
  assign sda_pull = ack_pull || (arm && lose);
endmodule

// file: verification/twmt_top_tb.sv
/*
  Testbench for the two-wire master transmitter: register tasks on the
  register bus and command sequences with expected status codes.
  Assumes the slave model on a pulled-up bus.
*/
`timescale 1ns/1ps
module twmt_top_tb
  import twmt_pkg::*;
;
  logic        clk_sys = 1'h0, rst_b = 1'h0, nack = 1'h0, lose = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rv, ist, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, sda_pull;
  logic [1:0]  bresp, rresp, last_resp;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || sda_pull);
  int          fail_count = 0, samples_checked = 0;

  twmt_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .irq(irq));
  twmt_slave_model slave (.scl(scl), .sda(sda), .nack(nack), .lose(lose),
    .sda_pull(sda_pull));

  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    last_resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    last_resp = rresp;
    rready <= 1'h0;
  endtask

  // wait for the done interrupt, then compare the posted code
  task automatic wt(input logic [7:0] st);
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 600)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    rd(A_IRQ_STAT, ist);
    rd(A_STATUS, rv);
    chk(rv, {24'h0, st});
  endtask

  task automatic step(input logic [31:0] c, input logic [7:0] st);
    wr(A_CTRL, c);
    wt(st);
  endtask

  // no flag follows a stop, so poll for the idle code
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      rd(A_STATUS, rv);
      n++;
    end while (rv !== {24'h0, ST_IDLE} && n < 60);
    chk(rv, {24'h0, ST_IDLE});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a tenth of this
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    results();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'h1;
    rd(A_STATUS, rv);
    chk(rv, {24'h0, ST_IDLE});
    wr(A_IRQ_MASK, 32'h3);
    chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
    wr(A_DATA, 32'hA4);
    step(32'h3, ST_START);
    chk({31'h0, scl_oe}, 32'h1);
    step(32'h1, ST_AW_ACK);
    wr(A_DATA, 32'h55);
    step(32'h1, ST_DB_ACK);
    nack <= 1'h1;
    step(32'h1, ST_DB_NACK);
    nack <= 1'h0;
    step(32'h3, ST_RESTART);
    wr(A_DATA, 32'hA4);
    step(32'h9, ST_AW_ACK);
    step(32'h7, ST_START);
    nack <= 1'h1;
    step(32'h1, ST_AW_NACK);
    nack <= 1'h0;
    wr(A_CTRL, 32'h5);
    idle();
    rd(A_CTRL, rv);
    chk({31'h0, rv[CTRL_STOP_B]}, 32'h0);
    $display("test write sequence done");
    wr(A_DATA, 32'hA5);
    step(32'h3, ST_START);
    step(32'h1, ST_MR_ACK);
    rd(A_CTRL, rv);
    chk({31'h0, rv[CTRL_MRX_B]}, 32'h1);
    wr(A_CTRL, 32'h5);
    idle();
    $display("test read address done");
    wr(A_DATA, 32'hFF);
    step(32'h3, ST_START);
    lose <= 1'h1;
    step(32'h1, ST_ARB_LOST);
    chk(ist, 32'h3);
    wr(A_CTRL, 32'h3);
    repeat (30) @(posedge clk_sys);
    chk({31'h0, sda_oe}, 32'h0);
    lose <= 1'h0;
    wt(ST_START);
    lose <= 1'h1;
    step(32'h1, ST_ARB_LOST);
    lose <= 1'h0;
    wr(A_CTRL, 32'h1);
    idle();
    chk({31'h0, scl_oe}, 32'h0);
    $display("test arbitration done");
    rd(8'h40, rv);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    $display("test unmapped access done");
    results();
  end
endmodule
